// file: design/tpc_pkg.sv
// Constants and types of the timer channel with PWM and capture modes
package tpc_pkg;

  ////////////////////////////////////////////////////////////////
  // Register offsets, one byte each
  localparam logic [3:0] TPC_OFF_CTRL = 4'h0;
  localparam logic [3:0] TPC_OFF_CNT_H = 4'h1;
  localparam logic [3:0] TPC_OFF_CNT_L = 4'h2;
  localparam logic [3:0] TPC_OFF_PWM_H = 4'h3;
  localparam logic [3:0] TPC_OFF_PWM_L = 4'h4;
  localparam logic [3:0] TPC_OFF_RLD_H = 4'h5;
  localparam logic [3:0] TPC_OFF_RLD_L = 4'h6;
  localparam logic [3:0] TPC_OFF_STAT = 4'h7;
  localparam logic [3:0] TPC_OFF_MASK = 4'h8;

  ////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int TPC_CTRL_EN = 0;
  localparam int TPC_CTRL_CAP = 1;
  localparam int TPC_CTRL_POL = 2;
  localparam int TPC_CTRL_PSC_LO = 3;
  localparam int TPC_CTRL_PSC_W = 3;

  // Status and mask bit positions
  localparam int TPC_ST_WRAP = 0;
  localparam int TPC_ST_CAP = 1;

  ////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] TPC_CTRL_RST = 8'h00;
  localparam logic [15:0] TPC_CNT_RST = 16'h0001;
  localparam logic [15:0] TPC_PWM_RST = 16'h0000;
  localparam logic [15:0] TPC_RLD_RST = 16'hFFFF;
  localparam logic [1:0] TPC_IRQ_RST = 2'h0;

  // Count value every PWM pass restarts from
  localparam logic [15:0] TPC_CNT_RESTART = 16'h0001;

  ////////////////////////////////////////////////////////////////
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tpc_bus_req_t;

endpackage

// file: design/tpc_timer.sv
// Timer channel with PWM and capture modes behind a byte register port
module tpc_timer #(
  parameter int PSC_W = 3 // Prescale select width, factor 2**sel
) (
  input wire logic sys_clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire tpc_pkg::tpc_bus_req_t bus_i, // Register request
  input wire logic tin_i, // Timer input pin
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  output logic pwm_o, // Timer output pin
  output logic irq_o // Level interrupt
);
  import tpc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Elaboration check
  if (PSC_W != TPC_CTRL_PSC_W) begin : g_bad_psc
    $error("PSC_W must match the control field width");
  end

  localparam int DIV_W = (1 << PSC_W) - 1; // Prescaler count width

  ////////////////////////////////////////////////////////////////
  // Whole state of the block
  typedef struct packed {
    logic [7:0] ctrl; // Control byte
    logic [15:0] cnt; // Running count
    logic [15:0] pwm; // PWM value or capture
    logic [15:0] rld; // Reload value
    logic [1:0] stat; // Sticky events
    logic [1:0] mask; // Interrupt mask
    logic [DIV_W-1:0] psc; // Prescaler count
    logic [2:0] sync; // Input synchroniser and delay
    logic out; // Output level
    logic irq; // Interrupt level
    logic [7:0] rdata; // Read data
    logic [23:0] per; // Clocks since last wrap, checker helper
    logic full; // A clean period is being timed
  } tpc_state_t;

  tpc_state_t q; // Registered state
  tpc_state_t d; // Next state

  ////////////////////////////////////////////////////////////////
  // Decoded control and helper terms
  logic en; // Timer enabled
  logic cap_mode; // Capture mode selected
  logic pol; // Output polarity bit
  logic [PSC_W-1:0] psc_sel; // Prescale select
  logic [DIV_W-1:0] psc_lim; // Last prescaler count
  logic tick; // Counter advance
  logic wrap; // Count at reload this tick
  logic [15:0] cnt_nx; // Count after a tick
  logic edge_rise; // Synchronised rising edge
  logic edge_fall; // Synchronised falling edge
  logic cap_hit; // Capture event
  logic cnt_wr; // Software writes a count byte
  logic ctrl_wr; // Software writes control

  assign en = q.ctrl[TPC_CTRL_EN];
  assign cap_mode = q.ctrl[TPC_CTRL_CAP];
  assign pol = q.ctrl[TPC_CTRL_POL];
  assign psc_sel = q.ctrl[TPC_CTRL_PSC_LO +: PSC_W];
  assign cnt_wr = bus_i.wr && (bus_i.addr == TPC_OFF_CNT_H || bus_i.addr == TPC_OFF_CNT_L);
  assign ctrl_wr = bus_i.wr && bus_i.addr == TPC_OFF_CTRL;

  ////////////////////////////////////////////////////////////////
  // Prescaler and counter terms
  always_comb begin
    // Factor 2**sel system clocks per count
    psc_lim = DIV_W'((1 << psc_sel) - 1);
    tick = en && (q.psc == psc_lim);
    wrap = tick && (q.cnt == q.rld);
    // Restart at 0001H after reload, else step up
    cnt_nx = (q.cnt == q.rld) ? TPC_CNT_RESTART : q.cnt + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised input
  always_comb begin
    // Only the second and third stages are looked at
    edge_rise = q.sync[1] && !q.sync[2];
    edge_fall = !q.sync[1] && q.sync[2];
    // Polarity 0 picks rising, 1 picks falling
    cap_hit = en && cap_mode && (pol ? edge_fall : edge_rise);
  end

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;

    // Input pin through two flops plus one delay
    d.sync = {q.sync[1:0], tin_i};

    // Prescaler idles at zero while disabled
    if (!en || tick) begin
      d.psc = '0;
    end else begin
      d.psc = q.psc + DIV_W'(1);
    end

    // Count advances on prescaled system clock in both modes
    if (tick) begin
      d.cnt = cnt_nx;
    end

    // Output level follows mode
    if (!en || cap_mode) begin
      // Idle level is the polarity bit
      d.out = pol;
    end else if (tick) begin
      // Starting level up to PWM match, other level after
      d.out = (cnt_nx <= q.pwm) ? pol : !pol;
    end

    // Register writes, byte assembled sixteen bit values
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        TPC_OFF_CTRL: begin
          d.ctrl = bus_i.wdata;
        end
        TPC_OFF_CNT_H: begin
          // Loaded start only sets where first pass begins
          d.cnt[15:8] = bus_i.wdata;
        end
        TPC_OFF_CNT_L: begin
          d.cnt[7:0] = bus_i.wdata;
        end
        TPC_OFF_PWM_H: begin
          d.pwm[15:8] = bus_i.wdata;
        end
        TPC_OFF_PWM_L: begin
          d.pwm[7:0] = bus_i.wdata;
        end
        TPC_OFF_RLD_H: begin
          d.rld[15:8] = bus_i.wdata;
        end
        TPC_OFF_RLD_L: begin
          d.rld[7:0] = bus_i.wdata;
        end
        TPC_OFF_MASK: begin
          d.mask = bus_i.wdata[1:0];
        end
        default: begin
          // Status clears below, other offsets ignored
        end
      endcase
    end

    // Capture replaces the PWM value, wins over a write
    if (cap_hit) begin
      d.pwm = q.cnt;
    end

    // Sticky events, write one to clear, set wins
    d.stat = q.stat;
    if (bus_i.wr && bus_i.addr == TPC_OFF_STAT) begin
      d.stat = q.stat & ~bus_i.wdata[1:0];
    end
    if (wrap) begin
      d.stat[TPC_ST_WRAP] = 1'b1;
    end
    if (cap_hit) begin
      d.stat[TPC_ST_CAP] = 1'b1;
    end

    // Interrupt from the next status and mask
    d.irq = |(d.stat & d.mask);

    // Period checker helper, restarts at a wrap, idles while disabled
    if (wrap || !en) begin
      d.per = 24'h000000;
    end else begin
      d.per = q.per + 24'h000001;
    end

    // Helper armed at a wrap, disarmed by any write
    if (!en || bus_i.wr) begin
      d.full = 1'b0;
    end else if (wrap) begin
      d.full = 1'b1;
    end

    // Read data for one cycle only
    d.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        TPC_OFF_CTRL: begin
          d.rdata = q.ctrl;
        end
        TPC_OFF_CNT_H: begin
          d.rdata = q.cnt[15:8];
        end
        TPC_OFF_CNT_L: begin
          d.rdata = q.cnt[7:0];
        end
        TPC_OFF_PWM_H: begin
          d.rdata = q.pwm[15:8];
        end
        TPC_OFF_PWM_L: begin
          d.rdata = q.pwm[7:0];
        end
        TPC_OFF_RLD_H: begin
          d.rdata = q.rld[15:8];
        end
        TPC_OFF_RLD_L: begin
          d.rdata = q.rld[7:0];
        end
        TPC_OFF_STAT: begin
          d.rdata = {6'h00, q.stat};
        end
        TPC_OFF_MASK: begin
          d.rdata = {6'h00, q.mask};
        end
        default: begin
          // Unmapped offsets read zero
          d.rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q.ctrl <= TPC_CTRL_RST;
      q.cnt <= TPC_CNT_RST;
      q.pwm <= TPC_PWM_RST;
      q.rld <= TPC_RLD_RST;
      q.stat <= TPC_IRQ_RST;
      q.mask <= TPC_IRQ_RST;
      q.psc <= '0;
      q.sync <= 3'h0;
      q.out <= 1'b0;
      q.irq <= 1'b0;
      q.rdata <= 8'h00;
      // Checker helper starts disarmed
      q.per <= 24'h000000;
      q.full <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign rdata_o = q.rdata;
  assign pwm_o = q.out;
  assign irq_o = q.irq;

  ////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // Steps of a wrap, a PWM tick and a capture
  sequence s_wrap;
    wrap && !cnt_wr;
  endsequence

  sequence s_pwm_tick;
    en && !cap_mode && tick && !ctrl_wr;
  endsequence

  sequence s_capture;
    cap_hit && !cnt_wr;
  endsequence

  a_restart_one: assert property (s_wrap |=> q.cnt == 16'h0001)
    else $error("count did not restart at one");

  a_period_len: assert property (
    (wrap && q.full && !cap_mode) |-> (q.per + 24'h000001) == (24'(q.rld) << psc_sel))
    else $error("PWM period differs from reload times prescale");

  a_pol_zero: assert property (
    (s_pwm_tick and (!pol && cnt_nx <= q.pwm)) |=> !pwm_o ##0 q.cnt <= q.pwm)
    else $error("polarity zero output not low before match");

  a_pol_one: assert property (
    (s_pwm_tick and (pol && cnt_nx > q.pwm)) |=> !pwm_o)
    else $error("polarity one output not low after match");

  a_match_level: assert property (
    (s_pwm_tick and (cnt_nx <= q.pwm)) |=> pwm_o == $past(pol))
    else $error("output not at starting level before match");

  a_capture_value: assert property (
    s_capture |=> q.pwm == $past(q.cnt) && q.stat[TPC_ST_CAP])
    else $error("captured count not stored");

  a_edge_select: assert property (
    (en && cap_mode && q.sync[1] != q.sync[2]) |-> cap_hit == (pol ? !q.sync[1] : q.sync[1]))
    else $error("capture on wrong edge");

  a_cap_running: assert property (
    (en && cap_mode && tick && !wrap && !cnt_wr) |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("capture counter did not advance");

  a_cap_irq: assert property (
    (cap_hit && q.mask[TPC_ST_CAP]) |=> irq_o ##1 (irq_o || $past(bus_i.wr)))
    else $error("capture did not raise interrupt");

endmodule

// file: dv/tpc_pin_model.sv
// Pin-side model: drives the timer input pin and measures the output pin
module tpc_pin_model (
  input wire logic sys_clk_i, // System clock used for measuring
  input wire logic lvl_i, // Level the bench wants on the input pin
  input wire logic pwm_i, // Timer output pin
  output logic tin_o, // Timer input pin
  output logic [15:0] period_o, // Clocks between two output rises
  output logic [15:0] high_o // High clocks within that span
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_q = 1'b0; // Output level at the last clock
  logic [15:0] run_q = 16'h0000; // Clocks since the last rise
  logic [15:0] hi_q = 16'h0000; // High clocks since the last rise
  ////////////////////////////////////////////////////////////////
  // Pin settles after the bench moves it, well away from the clock edge
  assign #1.5 tin_o = lvl_i;
  // Output is observed as it appears at the pin
  always @(posedge sys_clk_i) begin
    prev_q <= pwm_i;
    // A rise closes one full period
    if (pwm_i && !prev_q) begin
      period_o <= run_q;
      high_o <= hi_q;
      run_q <= 16'h0001;
      hi_q <= 16'h0001;
    end else begin
      run_q <= run_q + 16'h0001;
      hi_q <= hi_q + 16'(pwm_i);
    end
  end
endmodule

// file: dv/tb.sv
// Self-checking bench for the timer channel
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tpc_pkg::*;
  logic sys_clk_i = 1'b0; // System clock
  logic reset_i = 1'b1; // Synchronous reset
  tpc_bus_req_t bus_q = '0; // Register request
  logic lvl_q = 1'b0; // Wanted input pin level
  logic tin, pwm, irq; // Pin and interrupt lines
  logic [7:0] rdata, a, b, d; // Read data and samples
  logic [15:0] per, hi, rld, pv; // Measured and programmed values
  logic [2:0] sel; // Prescale select
  int err_count = 0;
  int cmp_count = 0;
  int seed = 58;
  int t1, t2;
  ////////////////////////////////////////////////////////////////
  always #2 sys_clk_i = ~sys_clk_i;
  tpc_timer u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_i(bus_q), .tin_i(tin),
    .rdata_o(rdata), .pwm_o(pwm), .irq_o(irq));
  tpc_pin_model u_pin (.sys_clk_i(sys_clk_i), .lvl_i(lvl_q), .pwm_i(pwm), .tin_o(tin),
    .period_o(per), .high_o(hi));
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One write cycle
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge sys_clk_i);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dt};
    @(posedge sys_clk_i);
    bus_q.wr <= 1'b0;
  endtask
  // One read cycle, data taken in the following cycle
  task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
    @(posedge sys_clk_i);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge sys_clk_i);
    bus_q.rd <= 1'b0;
    #1 dt = rdata;
  endtask
  task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
    rd(ad, d);
    chk(16'(d), 16'(exp));
  endtask
  // Interrupt level two clocks after a register change
  task automatic irq_is(input logic v);
    repeat (2) @(posedge sys_clk_i);
    #1 chk(16'(irq), 16'(v));
  endtask
  // Bounded wait for the interrupt, counting clocks
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while (irq !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      err_count++;
      $display("unexpected at %0t: no interrupt", $time);
      final_report;
    end
  endtask
  function automatic logic [7:0] cw(input logic [2:0] s, input logic p, input logic cp, input logic e);
    return {2'b00, s, p, cp, e};
  endfunction
  // Program a disabled channel and clear all status
  task automatic setup(input logic [15:0] cv, input logic [7:0] ct);
    wr(TPC_OFF_CTRL, ct);
    wr(TPC_OFF_CNT_H, cv[15:8]);
    wr(TPC_OFF_CNT_L, cv[7:0]);
    wr(TPC_OFF_PWM_H, pv[15:8]);
    wr(TPC_OFF_PWM_L, pv[7:0]);
    wr(TPC_OFF_RLD_H, rld[15:8]);
    wr(TPC_OFF_RLD_L, rld[7:0]);
    wr(TPC_OFF_STAT, 8'h03);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rchk(TPC_OFF_CNT_L, 8'h01);
    rchk(TPC_OFF_RLD_H, 8'hFF);
    rchk(TPC_OFF_PWM_L, 8'h00);
    rchk(4'hC, 8'h00);
    // Random periods and duties, first pass is a corner case
    for (int i = 0; i < 5; i++) begin
      rld = 16'(8 + ({$random(seed)} % 256));
      pv = 16'(1 + ({$random(seed)} % (rld - 16'h0001)));
      sel = 3'({$random(seed)} % 4);
      if (i == 0) begin
        rld = 16'h0008;
        pv = 16'h0007;
        sel = 3'h0;
      end
      // Largest prescale on a short period
      if (i == 4) begin
        rld = 16'h0008;
        pv = 16'h0003;
        sel = 3'h7;
      end
      setup(16'h0001, cw(sel, i[0], 1'b0, 1'b0));
      wr(TPC_OFF_CTRL, cw(sel, i[0], 1'b0, 1'b1));
      repeat (3 * (int'(rld) << sel) + 8) @(posedge sys_clk_i);
      #1 chk(per, rld << sel);
      chk(hi, (i[0] ? pv : rld - pv) << sel);
    end
    // Loaded start count shortens the first pass only
    rld = 16'h0028;
    pv = 16'h000A;
    wr(TPC_OFF_MASK, 8'h01);
    setup(16'h0001, cw(3'h0, 1'b1, 1'b0, 1'b0));
    wr(TPC_OFF_CTRL, cw(3'h0, 1'b1, 1'b0, 1'b1));
    wait_irq(t1);
    setup(16'h0010, cw(3'h0, 1'b1, 1'b0, 1'b0));
    wr(TPC_OFF_CTRL, cw(3'h0, 1'b1, 1'b0, 1'b1));
    wait_irq(t2);
    chk(16'(t1 - t2), 16'h000F);
    wr(TPC_OFF_STAT, 8'h01);
    irq_is(1'b0);
    repeat (100) @(posedge sys_clk_i);
    #1 chk(per, rld);
    // Capture on each polarity, wrong edge first
    rld = 16'hFFFF;
    pv = 16'hABCD;
    for (int p = 0; p < 2; p++) begin
      // Second pass captures with the interrupt already unmasked
      wr(TPC_OFF_MASK, {6'h00, p[0], 1'b0});
      lvl_q <= ~p[0];
      setup(16'h0001, cw(3'h0, p[0], 1'b1, 1'b0));
      wr(TPC_OFF_CTRL, cw(3'h0, p[0], 1'b1, 1'b1));
      lvl_q <= p[0];
      repeat (8) @(posedge sys_clk_i);
      rchk(TPC_OFF_STAT, 8'h00);
      rd(TPC_OFF_CNT_L, a);
      lvl_q <= ~p[0];
      repeat (8) @(posedge sys_clk_i);
      rd(TPC_OFF_CNT_L, b);
      rchk(TPC_OFF_STAT, 8'h02);
      chk(16'(b > a), 16'h0001);
      rchk(TPC_OFF_PWM_H, 8'h00);
      rd(TPC_OFF_PWM_L, d);
      chk(16'(d >= a && d <= b), 16'h0001);
      chk(16'(irq), 16'(p[0]));
      wr(TPC_OFF_MASK, 8'h02);
      irq_is(1'b1);
      wr(TPC_OFF_STAT, 8'h02);
      irq_is(1'b0);
    end
    final_report;
  end
endmodule
